// ### common/mmd_consts.svh
// Address boundaries, page numbers and select count for the memory map decoder
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH
`define MMD_IO_LO 16'h0000
`define MMD_IO_HI 16'h003f
`define MMD_IO2_LO 16'h0040
`define MMD_IO2_HI 16'h004f
`define MMD_RAM_A_LO 16'h0050
`define MMD_RAM_A_HI 16'h044f
`define MMD_FLB1_LO 16'h0450
`define MMD_FLB1_HI 16'h04ff
`define MMD_CAN_LO 16'h0500
`define MMD_CAN_HI 16'h057f
`define MMD_FLB2_LO 16'h0580
`define MMD_FLB2_HI 16'h05ff
`define MMD_EE_B_LO 16'h0600
`define MMD_EE_B_HI 16'h07ff
`define MMD_EE_A_LO 16'h0800
`define MMD_EE_A_HI 16'h09ff
`define MMD_RAM_B_LO 16'h0a00
`define MMD_RAM_B_HI 16'h0dff
`define MMD_FLB3_LO 16'h0e00
`define MMD_FLB3_HI 16'h7fff
`define MMD_FLA_LO 16'h8000
`define MMD_FLA_HI 16'hfdff
`define MMD_MON_LO 16'hfe20
`define MMD_MON_HI 16'hfeff
`define MMD_UNIMP_LO 16'hff00
`define MMD_UNIMP_HI 16'hff7f
`define MMD_RSV_LO 16'hff82
`define MMD_RSV_HI 16'hffcb
`define MMD_VEC_LO 16'hffcc
`define MMD_VEC_HI 16'hffff
`define MMD_SYS_PAGE 8'hfe
`define MMD_HIGH_PAGE 8'hff
`define MMD_NUM_SEL 32
`endif

// ### common/mmd_pkg.sv
// Types for the memory map decoder
`default_nettype none
package mmd_pkg;
  typedef enum logic [4:0] {
    MMD_SEL_IO = 5'h00, MMD_SEL_IO2 = 5'h01, MMD_SEL_RAM_A = 5'h02, MMD_SEL_RAM_B = 5'h03,
    MMD_SEL_FLASH_A = 5'h04, MMD_SEL_FLASH_B = 5'h05, MMD_SEL_CAN = 5'h06, MMD_SEL_EE_A = 5'h07,
    MMD_SEL_EE_B = 5'h08, MMD_SEL_MONITOR = 5'h09, MMD_SEL_VECTOR = 5'h0a, MMD_SEL_BRK_STAT = 5'h0b,
    MMD_SEL_RST_CAUSE = 5'h0c, MMD_SEL_BRK_FLAG = 5'h0d, MMD_SEL_CONFIG = 5'h0e, MMD_SEL_FLA_CTRL = 5'h0f,
    MMD_SEL_BRK_HI = 5'h10, MMD_SEL_BRK_LO = 5'h11, MMD_SEL_BRK_CS = 5'h12, MMD_SEL_LV_STAT = 5'h13,
    MMD_SEL_FLB_CTRL = 5'h14, MMD_SEL_EEB_NV = 5'h15, MMD_SEL_EEB_CTRL = 5'h16, MMD_SEL_EEB_CFG = 5'h17,
    MMD_SEL_EEA_NV = 5'h18, MMD_SEL_EEA_CTRL = 5'h19, MMD_SEL_EEA_CFG = 5'h1a, MMD_SEL_FLA_PROT = 5'h1b,
    MMD_SEL_FLB_PROT = 5'h1c, MMD_SEL_RESERVED = 5'h1d, MMD_SEL_UNIMP = 5'h1e, MMD_SEL_NONE = 5'h1f
  } mmd_region_type;
endpackage : mmd_pkg
`default_nettype wire

// ### hw/mmd_range_cmp.sv
// Inclusive address range comparator
`timescale 1ns/10ps
`default_nettype none
module mmd_range_cmp #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hffff
) (
  input wire logic [15:0] addr,
  output logic hit
);
  assign hit = (addr >= LO) && (addr <= HI);
endmodule : mmd_range_cmp
`default_nettype wire

// ### hw/mmd_sys_page.sv
// Decode of the 32-byte system page at $FE00-$FE1F
`timescale 1ns/10ps
`default_nettype none
`include "mmd_consts.svh"
module mmd_sys_page (
  input wire logic [4:0] low_addr,
  output mmd_pkg::mmd_region_type region
);
  always_comb begin
    case (low_addr)
      5'h00: region = mmd_pkg::MMD_SEL_BRK_STAT;
      5'h01: region = mmd_pkg::MMD_SEL_RST_CAUSE;
      5'h03: region = mmd_pkg::MMD_SEL_BRK_FLAG;
      5'h06: region = mmd_pkg::MMD_SEL_UNIMP;
      5'h09: region = mmd_pkg::MMD_SEL_CONFIG;
      5'h0b: region = mmd_pkg::MMD_SEL_FLA_CTRL;
      5'h0c: region = mmd_pkg::MMD_SEL_BRK_HI;
      5'h0d: region = mmd_pkg::MMD_SEL_BRK_LO;
      5'h0e: region = mmd_pkg::MMD_SEL_BRK_CS;
      5'h0f: region = mmd_pkg::MMD_SEL_LV_STAT;
      5'h11: region = mmd_pkg::MMD_SEL_FLB_CTRL;
      5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17: region = mmd_pkg::MMD_SEL_UNIMP;
      5'h18: region = mmd_pkg::MMD_SEL_EEB_NV;
      5'h19: region = mmd_pkg::MMD_SEL_EEB_CTRL;
      5'h1b: region = mmd_pkg::MMD_SEL_EEB_CFG;
      5'h1c: region = mmd_pkg::MMD_SEL_EEA_NV;
      5'h1d: region = mmd_pkg::MMD_SEL_EEA_CTRL;
      5'h1f: region = mmd_pkg::MMD_SEL_EEA_CFG;
      default: region = mmd_pkg::MMD_SEL_RESERVED;
    endcase
  end
endmodule : mmd_sys_page
`default_nettype wire

// ### hw/mmd_decoder.sv
// Memory map address decoder for the 64-Kbyte processor bus
// Overview of operation
// R1: One select per implemented 16-bit address
// R2: $0000-$003F selects primary register window
// R3: $0040-$004F selects second register window
// R4: $0500-$057F selects CAN area
// R5: FLASH B low pieces, FLASH A high
// R6: EEPROM B $0600, EEPROM A $0800
// R7: $FE20-$FEFF selects monitor ROM
// R8: Top 52 bytes select user vectors
// R9: Reserved locations flagged; software avoids them
// R10: Unimplemented access requests reset when enabled
// R11: Break status, reset cause, break flag selects
// R12: FLASH A/B control at $FE0B/$FE11
// R13: Break address high/low at $FE0C/$FE0D
// R14: Break status/control at $FE0E
// R15: Low-voltage status at $FE0F
// R16: EEPROM B register selects $FE18-$FE1B
// R17: EEPROM A register selects $FE1C-$FE1F
// R18: FLASH protect selects $FF80/$FF81
// R19: Configuration register select at $FE09
// R20: RAM A $0050-$044F, RAM B $0A00-$0DFF
// R21: Combinational selects, registered reset request
`timescale 1ns/10ps
`default_nettype none
`include "mmd_consts.svh"
module mmd_decoder (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [15:0] bus_addr,
  input wire logic bus_valid,
  input wire logic illegal_reset_enable,
  output logic [`MMD_NUM_SEL-1:0] region_select,
  output logic io_select,
  output logic io2_select,
  output logic ram_a_select,
  output logic ram_b_select,
  output logic flash_a_select,
  output logic flash_b_select,
  output logic can_select,
  output logic eeprom_a_select,
  output logic eeprom_b_select,
  output logic monitor_select,
  output logic vector_select,
  output logic break_status_select,
  output logic reset_cause_status_select,
  output logic break_flag_control_select,
  output logic config_select,
  output logic flash_a_control_select,
  output logic break_addr_high_select,
  output logic break_addr_low_select,
  output logic break_ctrl_status_select,
  output logic low_voltage_status_select,
  output logic flash_b_control_select,
  output logic eeprom_b_nonvol_select,
  output logic eeprom_b_control_select,
  output logic eeprom_b_array_cfg_select,
  output logic eeprom_a_nonvol_select,
  output logic eeprom_a_control_select,
  output logic eeprom_a_array_cfg_select,
  output logic flash_a_protect_select,
  output logic flash_b_protect_select,
  output logic reserved_access,
  output logic unimpl_access,
  output logic illegal_reset_req
);
  ////////////////////////////////////////////////////////////////////////////
  // Range hits
  localparam int NR = 14;
  localparam logic [15:0] LO_TAB [NR] = '{`MMD_IO_LO, `MMD_IO2_LO, `MMD_RAM_A_LO, `MMD_FLB1_LO,
    `MMD_CAN_LO, `MMD_FLB2_LO, `MMD_EE_B_LO, `MMD_EE_A_LO, `MMD_RAM_B_LO, `MMD_FLB3_LO,
    `MMD_FLA_LO, `MMD_MON_LO, `MMD_UNIMP_LO, `MMD_RSV_LO};
  localparam logic [15:0] HI_TAB [NR] = '{`MMD_IO_HI, `MMD_IO2_HI, `MMD_RAM_A_HI, `MMD_FLB1_HI,
    `MMD_CAN_HI, `MMD_FLB2_HI, `MMD_EE_B_HI, `MMD_EE_A_HI, `MMD_RAM_B_HI, `MMD_FLB3_HI,
    `MMD_FLA_HI, `MMD_MON_HI, `MMD_UNIMP_HI, `MMD_RSV_HI};
  logic [NR-1:0] hit;
  genvar gi;
  generate
    for (gi = 0; gi < NR; gi = gi + 1) begin : g_rng
      mmd_range_cmp #(.LO(LO_TAB[gi]), .HI(HI_TAB[gi])) u_cmp (
        .addr(bus_addr),
        .hit(hit[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // System page
  mmd_pkg::mmd_region_type sys_region;
  mmd_sys_page u_sys (
    .low_addr(bus_addr[4:0]),
    .region(sys_region)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Region priority, one region per address
  mmd_pkg::mmd_region_type region;
  always_comb begin
    region = mmd_pkg::MMD_SEL_NONE;
    if (hit[0]) begin
      region = mmd_pkg::MMD_SEL_IO; // see R2
    end else if (hit[1]) begin
      region = mmd_pkg::MMD_SEL_IO2; // see R3
    end else if (hit[2] || hit[8]) begin
      region = hit[2] ? mmd_pkg::MMD_SEL_RAM_A : mmd_pkg::MMD_SEL_RAM_B; // see R20
    end else if (hit[3] || hit[5] || hit[9]) begin
      region = mmd_pkg::MMD_SEL_FLASH_B; // see R5
    end else if (hit[10]) begin
      region = mmd_pkg::MMD_SEL_FLASH_A; // see R5
    end else if (hit[4]) begin
      region = mmd_pkg::MMD_SEL_CAN; // see R4
    end else if (hit[6]) begin
      region = mmd_pkg::MMD_SEL_EE_B; // see R6
    end else if (hit[7]) begin
      region = mmd_pkg::MMD_SEL_EE_A; // see R6
    end else if (hit[11]) begin
      region = mmd_pkg::MMD_SEL_MONITOR; // see R7
    end else if (bus_addr[15:8] == `MMD_SYS_PAGE) begin
      region = sys_region; // see R11
    end else if (hit[12]) begin
      region = mmd_pkg::MMD_SEL_UNIMP; // see R10
    end else if (bus_addr == {`MMD_HIGH_PAGE, 8'h80}) begin
      region = mmd_pkg::MMD_SEL_FLA_PROT; // see R18
    end else if (bus_addr == {`MMD_HIGH_PAGE, 8'h81}) begin
      region = mmd_pkg::MMD_SEL_FLB_PROT; // see R18
    end else if (hit[13]) begin
      region = mmd_pkg::MMD_SEL_RESERVED; // see R9
    end else if (bus_addr >= `MMD_VEC_LO) begin
      region = mmd_pkg::MMD_SEL_VECTOR; // see R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-hot selects
  always_comb begin
    region_select = '0;
    region_select[region] = 1'b1; // see R1
  end
  assign io_select = region_select[mmd_pkg::MMD_SEL_IO];
  assign io2_select = region_select[mmd_pkg::MMD_SEL_IO2];
  assign ram_a_select = region_select[mmd_pkg::MMD_SEL_RAM_A];
  assign ram_b_select = region_select[mmd_pkg::MMD_SEL_RAM_B];
  assign flash_a_select = region_select[mmd_pkg::MMD_SEL_FLASH_A];
  assign flash_b_select = region_select[mmd_pkg::MMD_SEL_FLASH_B];
  assign can_select = region_select[mmd_pkg::MMD_SEL_CAN];
  assign eeprom_a_select = region_select[mmd_pkg::MMD_SEL_EE_A];
  assign eeprom_b_select = region_select[mmd_pkg::MMD_SEL_EE_B];
  assign monitor_select = region_select[mmd_pkg::MMD_SEL_MONITOR];
  assign vector_select = region_select[mmd_pkg::MMD_SEL_VECTOR];
  assign break_status_select = region_select[mmd_pkg::MMD_SEL_BRK_STAT];
  assign reset_cause_status_select = region_select[mmd_pkg::MMD_SEL_RST_CAUSE];
  assign break_flag_control_select = region_select[mmd_pkg::MMD_SEL_BRK_FLAG];
  assign config_select = region_select[mmd_pkg::MMD_SEL_CONFIG]; // see R19
  assign flash_a_control_select = region_select[mmd_pkg::MMD_SEL_FLA_CTRL]; // see R12
  assign break_addr_high_select = region_select[mmd_pkg::MMD_SEL_BRK_HI]; // see R13
  assign break_addr_low_select = region_select[mmd_pkg::MMD_SEL_BRK_LO]; // see R13
  assign break_ctrl_status_select = region_select[mmd_pkg::MMD_SEL_BRK_CS]; // see R14
  assign low_voltage_status_select = region_select[mmd_pkg::MMD_SEL_LV_STAT]; // see R15
  assign flash_b_control_select = region_select[mmd_pkg::MMD_SEL_FLB_CTRL]; // see R12
  assign eeprom_b_nonvol_select = region_select[mmd_pkg::MMD_SEL_EEB_NV]; // see R16
  assign eeprom_b_control_select = region_select[mmd_pkg::MMD_SEL_EEB_CTRL]; // see R16
  assign eeprom_b_array_cfg_select = region_select[mmd_pkg::MMD_SEL_EEB_CFG]; // see R16
  assign eeprom_a_nonvol_select = region_select[mmd_pkg::MMD_SEL_EEA_NV]; // see R17
  assign eeprom_a_control_select = region_select[mmd_pkg::MMD_SEL_EEA_CTRL]; // see R17
  assign eeprom_a_array_cfg_select = region_select[mmd_pkg::MMD_SEL_EEA_CFG]; // see R17
  assign flash_a_protect_select = region_select[mmd_pkg::MMD_SEL_FLA_PROT];
  assign flash_b_protect_select = region_select[mmd_pkg::MMD_SEL_FLB_PROT];
  assign reserved_access = region_select[mmd_pkg::MMD_SEL_RESERVED]; // see R9
  assign unimpl_access = region_select[mmd_pkg::MMD_SEL_UNIMP];

  ////////////////////////////////////////////////////////////////////////////
  // Illegal-address reset request
  logic illegal_reset_req_r;
  logic illegal_reset_req_nxt;
  always_comb begin
    illegal_reset_req_nxt = bus_valid && unimpl_access && illegal_reset_enable; // see R10
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      illegal_reset_req_r <= 1'b0; // see R21
    end else if (clk_en) begin
      illegal_reset_req_r <= illegal_reset_req_nxt;
    end
  end
  assign illegal_reset_req = illegal_reset_req_r;
endmodule : mmd_decoder
`default_nettype wire

// ### testbench/mmd_decoder_sva.sv
// Port checker for the memory map decoder
`timescale 1ns/10ps
`default_nettype none
`include "mmd_consts.svh"
module mmd_decoder_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [15:0] bus_addr,
  input wire logic bus_valid,
  input wire logic illegal_reset_enable,
  input wire logic [`MMD_NUM_SEL-1:0] region_select,
  input wire logic reserved_access,
  input wire logic unimpl_access,
  input wire logic illegal_reset_req
);
  logic cause;
  assign cause = clk_en && bus_valid && unimpl_access && illegal_reset_enable;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_one_hot_sel: assert property ($onehot(region_select))
    else $error("selects not one-hot");
  a_io_windows: assert property (region_select[1:0] == {bus_addr[15:4] == 12'h004, bus_addr < 16'h0040})
    else $error("io window select");
  a_eeprom_banks: assert property (region_select[8:7] == {bus_addr[15:9] == 7'h03, bus_addr[15:9] == 7'h04})
    else $error("eeprom bank select");
  a_mon_vector: assert property (region_select[10:9] ==
    {bus_addr >= 16'hffcc, bus_addr inside {[16'hfe20:16'hfeff]}})
    else $error("monitor or vector select");
  a_reserved_flag: assert property (reserved_access == (bus_addr inside {16'hfe02, 16'hfe04, 16'hfe05, 16'hfe07,
    16'hfe08, 16'hfe0a, 16'hfe10, 16'hfe1a, 16'hfe1e, [16'hff82:16'hffcb]})) else $error("reserved flag");
  a_unimpl_flag: assert property (unimpl_access ==
    (bus_addr inside {16'hfe06, [16'hfe12:16'hfe17], [16'hff00:16'hff7f]}))
    else $error("unimplemented flag");
  a_req_follows: assert property (cause |=> illegal_reset_req)
    else $error("request missing");
  a_req_cause: assert property (illegal_reset_req |->
    $past(cause) || ($past(illegal_reset_req) && !$past(clk_en)))
    else $error("request without cause");
endmodule : mmd_decoder_sva
bind mmd_decoder mmd_decoder_sva i_mmd_decoder_sva (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
  .bus_addr(bus_addr), .bus_valid(bus_valid), .illegal_reset_enable(illegal_reset_enable),
  .region_select(region_select), .reserved_access(reserved_access), .unimpl_access(unimpl_access),
  .illegal_reset_req(illegal_reset_req));
`default_nettype wire

// ### testbench/mmd_cpu_model.sv
// Processor core model driving the address bus
`timescale 1ns/10ps
`default_nettype none
module mmd_cpu_model (
  input wire logic [15:0] req_addr,
  input wire logic req_valid,
  output logic [15:0] bus_addr,
  output logic bus_valid
);
  // Idle cycles still drive the bus, never a copy of the wanted address
  assign bus_valid = req_valid;
  assign bus_addr = req_valid ? req_addr : ~req_addr;
endmodule : mmd_cpu_model
`default_nettype wire

// ### testbench/tb_mmd_decoder.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/10ps
`default_nettype none
module tb_mmd_decoder;
  logic clk, reset_n, clk_en, req_valid, bus_valid, illegal_reset_enable, illegal_reset_req, exp_req;
  logic [15:0] req_addr, bus_addr;
  logic [31:0] region_select;
  logic io_select, io2_select, ram_a_select, ram_b_select, flash_a_select, flash_b_select, can_select, config_select;
  logic eeprom_a_select, eeprom_b_select, monitor_select, vector_select, break_status_select, reserved_access;
  logic reset_cause_status_select, break_flag_control_select, flash_a_control_select, break_addr_high_select;
  logic break_addr_low_select, break_ctrl_status_select, low_voltage_status_select, flash_b_control_select;
  logic eeprom_b_nonvol_select, eeprom_b_control_select, eeprom_b_array_cfg_select, eeprom_a_nonvol_select;
  logic eeprom_a_control_select, eeprom_a_array_cfg_select, flash_a_protect_select, flash_b_protect_select;
  logic unimpl_access;
  logic [31:0] sel_bits;
  // Single selects gathered in region index order, so they can be held against the one-hot expectation
  assign sel_bits = {1'b0, unimpl_access, reserved_access, flash_b_protect_select, flash_a_protect_select,
    eeprom_a_array_cfg_select, eeprom_a_control_select, eeprom_a_nonvol_select, eeprom_b_array_cfg_select,
    eeprom_b_control_select, eeprom_b_nonvol_select, flash_b_control_select, low_voltage_status_select,
    break_ctrl_status_select, break_addr_low_select, break_addr_high_select, flash_a_control_select, config_select,
    break_flag_control_select, reset_cause_status_select, break_status_select, vector_select, monitor_select,
    eeprom_b_select, eeprom_a_select, can_select, flash_b_select, flash_a_select, ram_b_select, ram_a_select,
    io2_select, io_select};
  int n_mismatch, n_tests, n_cyc;
  logic [15:0] top [14] = '{16'h003f, 16'h004f, 16'h044f, 16'h04ff, 16'h057f, 16'h05ff, 16'h07ff, 16'h09ff,
    16'h0dff, 16'h7fff, 16'hfdff, 16'hfeff, 16'hff7f, 16'hffcb};
  logic [4:0] idx [14] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h06, 5'h05, 5'h08, 5'h07, 5'h03, 5'h05, 5'h04, 5'h09,
    5'h1e, 5'h1d};
  logic [4:0] sys [32] = '{5'h0b, 5'h0c, 5'h1d, 5'h0d, 5'h1d, 5'h1d, 5'h1e, 5'h1d, 5'h1d, 5'h0e, 5'h1d, 5'h0f,
    5'h10, 5'h11, 5'h12, 5'h13, 5'h1d, 5'h14, 5'h1e, 5'h1e, 5'h1e, 5'h1e, 5'h1e, 5'h1e, 5'h15, 5'h16, 5'h1d,
    5'h17, 5'h18, 5'h19, 5'h1d, 5'h1a};
  mmd_decoder i_mmd_decoder (.*);
  mmd_cpu_model i_mmd_cpu_model (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (++n_cyc == 4000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] exp_idx(input logic [15:0] a);
    if (a[15:5] == 11'h7f0) return sys[a[4:0]];
    if (a[15:1] == 15'h7fc0) return 5'h1b + 5'(a[0]);
    foreach (top[i]) if (a <= top[i]) return idx[i];
    return 5'h0a;
  endfunction : exp_idx
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input logic [15:0] a, input logic v, e, c, r);
    logic [31:0] exp_sel;
    @(negedge clk);
    chk({31'h0, illegal_reset_req}, {31'h0, exp_req});
    {req_addr, req_valid, illegal_reset_enable, clk_en, reset_n} = {a, v, e, c, r};
    exp_sel = 32'h1 << exp_idx(v ? a : ~a);
    #1 chk(region_select, exp_sel);
    chk(sel_bits, exp_sel);
    @(posedge clk);
    if (!r) exp_req = 1'b0;
    else if (c) exp_req = v && e && exp_idx(a) == 5'h1e;
  endtask : cyc
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {req_addr, req_valid, illegal_reset_enable, clk_en, reset_n, exp_req} = '0;
    void'($urandom(32'h3f0a));
    repeat (6) @(negedge clk);
    foreach (top[i]) begin
      for (int k = 0; k < 2; k++) begin
        cyc(top[i] + 16'(k), 1'b1, 1'b1, 1'b1, 1'b1);
      end
    end
    for (int i = 0; i < 34; i++) begin
      cyc(16'hfe00 + 16'(i), 1'b1, 1'b1, 1'b1, 1'b1);
    end
    cyc(16'hff81, 1'b1, 1'b1, 1'b1, 1'b1);
    cyc(16'hffff, 1'b1, 1'b1, 1'b1, 1'b1);
    cyc(16'hfe06, 1'b1, 1'b1, 1'b1, 1'b1);
    cyc(16'h0000, 1'b1, 1'b1, 1'b0, 1'b1);
    cyc(16'hff00, 1'b1, 1'b0, 1'b1, 1'b1);
    cyc(16'h00ff, 1'b0, 1'b1, 1'b1, 1'b1);
    cyc(16'hfe12, 1'b1, 1'b1, 1'b1, 1'b0);
    repeat (2000) cyc($urandom % 3 == 0 ? 16'hff00 | 16'($urandom % 256) : 16'($urandom), 1'($urandom), 1'($urandom),
      1'($urandom % 4 != 0), 1'b1);
    cyc(16'h0000, 1'b1, 1'b1, 1'b1, 1'b1);
    tally_and_finish();
  end
endmodule : tb_mmd_decoder
`default_nettype wire
